// >>> hdl/rsc_map.vh
// Register map and timing constants of the reset source collector
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_ADDR_W 4
`define RSC_OFS_CAUSE 4'h0
`define RSC_OFS_CTRL 4'h4
`define RSC_OFS_STAT 4'h8
`define RSC_CAUSE_MASK 16'hc2df
`define RSC_CAUSE_RST 16'h0003
`define RSC_CTRL_RST 32'h0000_0000
`define RSC_B_POR 0
`define RSC_B_BOR 1
`define RSC_B_IDLE 2
`define RSC_B_SLEEP 3
`define RSC_B_WDT 4
`define RSC_B_SOFT 6
`define RSC_B_PIN 7
`define RSC_B_MISM 9
`define RSC_B_ILL 14
`define RSC_B_TRAP 15
`define RSC_CLK_MHZ 125
`define RSC_BOR_EXT_US 100
`define RSC_BOR_EXT_CYC (`RSC_BOR_EXT_US * `RSC_CLK_MHZ)
`define RSC_PIN_MIN_NS 2000
`define RSC_PIN_MIN_CYC ((`RSC_PIN_MIN_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_ILL_OPCODE 8'h3f
`define RSC_HARD_TRAP_LO 4'hd
`define RSC_HARD_TRAP_HI 4'hf
`define RSC_DLY_W 25
`endif

// >>> hdl/rsc_reset_collector.v
// Reset source collector with reset-cause status register
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "rsc_map.vh"
module rsc_reset_collector #(
  parameter [24:0] P_MS_CYC = 25'd125000,
  parameter [24:0] P_BOR_EXT_CYC = `RSC_BOR_EXT_CYC
)(
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_por,
  input wire i_bor,
  input wire i_ext_reset_n,
  input wire [2:0] i_power_up_delay_select,
  input wire i_soft_reset_instr,
  input wire i_wdt_timeout,
  input wire i_in_sleep,
  input wire i_in_idle,
  input wire i_watchdog_clear_instr,
  input wire i_power_save_sleep,
  input wire i_power_save_idle,
  input wire i_trap_active,
  input wire [3:0] i_trap_active_lvl,
  input wire i_trap_req,
  input wire [3:0] i_trap_req_lvl,
  input wire i_shadow_mismatch,
  input wire i_exec_valid,
  input wire [23:0] i_exec_word,
  input wire i_ptr_use,
  input wire i_ptr_uninit,
  input wire i_flow_change,
  input wire i_flow_restricted,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  output wire o_system_reset_line,
  output wire o_cold_reset,
  output reg o_wake,
  output reg [14:0] o_wreg_valid
);
  reg [2:0] pin_sync_r;
  reg pin_low_r;
  reg [15:0] pin_cnt_r;
  reg [24:0] dly_cnt_r;
  reg [2:0] dly_ms_r;
  reg [7:0] dly_ms_left_r;
  reg hold_r;
  reg [15:0] cause_r;
  reg [15:0] cause_nxt;
  reg ack_r;
  reg warm_r;
  wire pin_rst;
  wire trap_conflict;
  wire ill_op;
  wire ill_ptr;
  wire ill_sec;
  wire wdt_rst;
  wire warm_evt;
  wire sel_cause;
  wire sel_stat;

  function [7:0] rsc_ms_of;
    input [2:0] sel;
    begin
      rsc_ms_of = (sel == 3'd0) ? 8'd0 : (8'd1 << sel);
    end
  endfunction

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      pin_sync_r <= 3'b111;
    else
      pin_sync_r <= {pin_sync_r[1:0], i_ext_reset_n};
  end

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pin_cnt_r <= 16'h0000;
      pin_low_r <= 1'b0;
    end
    else if (pin_sync_r[1] == pin_sync_r[2])
    begin
      if (pin_sync_r[2])
      begin
        pin_cnt_r <= 16'h0000;
        pin_low_r <= 1'b0;
      end
      else if (pin_cnt_r >= `RSC_PIN_MIN_CYC)
        pin_low_r <= 1'b1;
      else
        pin_cnt_r <= pin_cnt_r + 16'h0001;
    end
  end
  assign pin_rst = pin_low_r;

  assign trap_conflict = i_trap_active && i_trap_req &&
    (i_trap_req_lvl >= `RSC_HARD_TRAP_LO) &&
    (i_trap_req_lvl <= `RSC_HARD_TRAP_HI) &&
    (i_trap_req_lvl < i_trap_active_lvl);
  assign ill_op = i_exec_valid && (i_exec_word[23:16] == `RSC_ILL_OPCODE);
  assign ill_ptr = i_ptr_use && i_ptr_uninit;
  assign ill_sec = i_flow_change && i_flow_restricted;
  assign wdt_rst = i_wdt_timeout && !i_in_sleep && !i_in_idle;
  assign warm_evt = i_soft_reset_instr || wdt_rst || trap_conflict ||
    i_shadow_mismatch || ill_op || ill_ptr || ill_sec;

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      hold_r <= 1'b1;
      dly_cnt_r <= P_BOR_EXT_CYC;
      dly_ms_r <= 3'd0;
      dly_ms_left_r <= 8'd0;
    end
    else if (i_por || i_bor)
    begin
      hold_r <= 1'b1;
      dly_cnt_r <= P_BOR_EXT_CYC;
      dly_ms_r <= i_power_up_delay_select;
      dly_ms_left_r <= rsc_ms_of(i_power_up_delay_select);
    end
    else if (hold_r)
    begin
      if (dly_cnt_r != 25'd0)
        dly_cnt_r <= dly_cnt_r - 25'd1;
      else if (dly_ms_left_r != 8'd0)
      begin
        dly_ms_left_r <= dly_ms_left_r - 8'd1;
        dly_cnt_r <= P_MS_CYC - 25'd1;
      end
      else
        hold_r <= 1'b0;
    end
  end

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      warm_r <= 1'b0;
      o_wake <= 1'b0;
    end
    else
    begin
      warm_r <= warm_evt;
      o_wake <= i_wdt_timeout && (i_in_sleep || i_in_idle);
    end
  end
  assign o_system_reset_line = hold_r || i_por || i_bor || pin_rst ||
    warm_r || warm_evt;
  assign o_cold_reset = hold_r || i_por || i_bor;

  always @(posedge i_clk)
  begin
    if (i_sys_rst || o_system_reset_line)
      o_wreg_valid <= 15'h0000;
    else
      o_wreg_valid <= o_wreg_valid;
  end

  assign sel_cause = (i_avs_address == `RSC_OFS_CAUSE);
  assign sel_stat = (i_avs_address == `RSC_OFS_STAT);

  always @*
  begin
    cause_nxt = cause_r;
    if (i_avs_write && sel_cause && ack_r)
    begin
      if (i_avs_byteenable[0])
        cause_nxt[7:0] = i_avs_writedata[7:0];
      if (i_avs_byteenable[1])
        cause_nxt[15:8] = i_avs_writedata[15:8];
    end
    if (i_watchdog_clear_instr || i_power_save_sleep || i_power_save_idle)
      cause_nxt[`RSC_B_WDT] = 1'b0;
    // Brown-out keeps pin and power-on flags
    if (i_bor)
      cause_nxt = cause_nxt & 16'h0081;
    if (i_por)
      cause_nxt = 16'h0000;
    if (i_power_save_sleep)
      cause_nxt[`RSC_B_SLEEP] = 1'b1;
    if (i_power_save_idle)
      cause_nxt[`RSC_B_IDLE] = 1'b1;
    if (i_por)
      cause_nxt[`RSC_B_POR] = 1'b1;
    if (i_bor || i_por)
      cause_nxt[`RSC_B_BOR] = 1'b1;
    if (pin_rst)
      cause_nxt[`RSC_B_PIN] = 1'b1;
    if (i_soft_reset_instr)
      cause_nxt[`RSC_B_SOFT] = 1'b1;
    if (i_wdt_timeout)
      cause_nxt[`RSC_B_WDT] = 1'b1;
    if (trap_conflict)
      cause_nxt[`RSC_B_TRAP] = 1'b1;
    if (i_shadow_mismatch)
      cause_nxt[`RSC_B_MISM] = 1'b1;
    if (ill_op || ill_ptr || ill_sec)
      cause_nxt[`RSC_B_ILL] = 1'b1;
    cause_nxt = cause_nxt & `RSC_CAUSE_MASK;
  end

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      cause_r <= `RSC_CAUSE_RST;
    else
      cause_r <= cause_nxt;
  end

  // Bus answers one cycle after request
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ack_r <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= (i_avs_read || i_avs_write) && !ack_r;
      if (i_avs_read && !ack_r)
      begin
        if (sel_cause)
          o_avs_readdata <= {16'h0000, cause_r};
        else if (sel_stat)
          o_avs_readdata <= {27'h0, o_wake, hold_r, pin_rst, warm_r,
            o_system_reset_line};
        else
          o_avs_readdata <= 32'h0000_0000;
      end
    end
  end
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
endmodule // rsc_reset_collector

// >>> bench/rsc_checker.sv
// Assertion checker of the reset source collector
`timescale 1ns/1ps
module rsc_checker #(
  parameter [24:0] P_MS_CYC = 25'd125000,
  parameter [24:0] P_BOR_EXT_CYC = 25'd12500
)(
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_soft_reset_instr,
  input wire i_wdt_timeout,
  input wire i_in_sleep,
  input wire i_in_idle,
  input wire i_trap_active,
  input wire [3:0] i_trap_active_lvl,
  input wire i_trap_req,
  input wire [3:0] i_trap_req_lvl,
  input wire i_shadow_mismatch,
  input wire i_exec_valid,
  input wire [23:0] i_exec_word,
  input wire i_ptr_use,
  input wire i_ptr_uninit,
  input wire i_flow_change,
  input wire i_flow_restricted,
  input wire o_system_reset_line,
  input wire o_wake
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_soft_reset: assert property (i_soft_reset_instr |=> o_system_reset_line)
    else $error("soft reset missing");
  a_wdt_run: assert property (i_wdt_timeout && !i_in_sleep && !i_in_idle
    |-> ##[0:1] o_system_reset_line) else $error("watchdog reset missing");
  a_wdt_wake: assert property ((i_in_sleep || i_in_idle) && i_wdt_timeout
    |=> o_wake) else $error("wake missing");
  a_trap_conflict: assert property (i_trap_req && i_trap_active
    && i_trap_req_lvl >= 4'hd && i_trap_req_lvl < i_trap_active_lvl
    |=> o_system_reset_line) else $error("trap reset missing");
  a_shadow_mism: assert property (i_shadow_mismatch |=> o_system_reset_line)
    else $error("mismatch reset missing");
  a_illegal_op: assert property (i_exec_valid && i_exec_word[23:16] == 8'h3f
    |=> o_system_reset_line) else $error("opcode reset missing");
  a_ptr_uninit: assert property (i_ptr_use && i_ptr_uninit
    |=> o_system_reset_line) else $error("pointer reset missing");
  a_flow_restr: assert property (i_flow_change && i_flow_restricted
    |=> o_system_reset_line) else $error("security reset missing");
endmodule // rsc_checker
bind rsc_reset_collector rsc_checker #(.P_MS_CYC(P_MS_CYC),
  .P_BOR_EXT_CYC(P_BOR_EXT_CYC)) chk_u (.*);

// >>> bench/rsc_pin_model.sv
// Far-side model driving the external reset pin
`timescale 1ns/1ps
module rsc_pin_model (
  input wire i_clk,
  input wire i_go,
  input wire [9:0] i_len,
  output logic o_ext_reset_n
);
  logic [9:0] cnt_r = 10'h0;
  always @(posedge i_clk)
  begin
    if (i_go)
      cnt_r <= i_len;
    else if (cnt_r != 10'h0)
      cnt_r <= cnt_r - 10'h1;
  end
  assign o_ext_reset_n = (cnt_r == 10'h0);
endmodule // rsc_pin_model

// >>> bench/testbench.sv
// Self-checking bench of the reset source collector
`timescale 1ns/1ps
module testbench;
  logic i_clk, i_sys_rst, i_por, i_bor, i_ext_reset_n, i_soft_reset_instr;
  logic i_wdt_timeout, i_in_sleep, i_in_idle, i_watchdog_clear_instr;
  logic i_power_save_sleep, i_power_save_idle, i_trap_active, i_trap_req;
  logic i_shadow_mismatch, i_exec_valid, i_ptr_use, i_ptr_uninit, pin_go;
  logic i_flow_change, i_flow_restricted, i_avs_read, i_avs_write, o_wake;
  logic o_avs_waitrequest, o_system_reset_line, o_cold_reset;
  logic [2:0] i_power_up_delay_select;
  logic [3:0] i_trap_active_lvl, i_trap_req_lvl, i_avs_address;
  logic [3:0] i_avs_byteenable;
  logic [23:0] i_exec_word;
  logic [31:0] i_avs_writedata, o_avs_readdata, x, r;
  logic [14:0] o_wreg_valid, ev;
  logic [15:0] exp_q[$], pre;
  logic [9:0] pin_len;
  int n_errors, samples_checked;
  logic [14:0] ev_t [17] = '{15'h2000, 15'h1000, 15'h0800, 15'h0400,
    15'h0200, 15'h0180, 15'h0060, 0, 0, 15'h5000, 15'h0008, 15'h0004,
    15'h0002, 15'h0010, 15'h0001, 0, 15'h0200};
  logic [15:0] ex_t [17] = '{16'h0040, 16'h0010, 16'h8000, 16'h0200,
    16'h4000, 16'h4000, 16'h4000, 16'h0080, 0, 16'h0010, 16'h0008,
    16'h0004, 16'h0003, 0, 16'h0083, 0, 0};
  assign {i_in_sleep, i_soft_reset_instr, i_wdt_timeout, i_trap_req,
    i_shadow_mismatch, i_exec_valid, i_ptr_use, i_ptr_uninit, i_flow_change,
    i_flow_restricted, i_watchdog_clear_instr, i_power_save_sleep,
    i_power_save_idle, i_por, i_bor} = ev;
  rsc_reset_collector #(.P_MS_CYC(25'd10), .P_BOR_EXT_CYC(25'd5)) dut_u (.*);
  rsc_pin_model pm_u (.i_clk(i_clk), .i_go(pin_go), .i_len(pin_len),
    .o_ext_reset_n(i_ext_reset_n));
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= {16'h0, d};
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic settle();
    repeat (3000) if (o_system_reset_line !== 1'b0) @(posedge i_clk);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge i_clk)
    if (i_avs_read && o_avs_waitrequest === 1'b0)
      check(o_avs_readdata[15:0], exp_q.pop_front());
  initial
  begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (80000) @(posedge i_clk);
    n_errors++;
    close_out();
  end
  initial
  begin
    {ev, pin_go, pin_len, i_avs_read, i_avs_write, i_avs_address} = 0;
    {i_avs_writedata, i_exec_word, i_power_up_delay_select, i_in_idle} = 0;
    {i_sys_rst, i_trap_active, i_trap_active_lvl, i_trap_req_lvl} = 10'h3fd;
    i_avs_byteenable = 4'hf;
    x = 95;
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    settle();
    exp_q.push_back(16'h0003);
    bus(1'b0, 4'h0, 16'h0);
    for (int k = 0; k < 17; k++)
    begin
      r = rnd();
      i_power_up_delay_select <= r[2:0];
      i_exec_word <= {(k == 16) ? 8'h3e : 8'h3f, r[15:0]};
      pre = (k == 12 || k == 14) ? 16'hffff : (k == 10 || k == 13) ? 16'h0010
        : (k == 15) ? r[15:0] : 16'h0;
      bus(1'b1, 4'h0, pre);
      @(posedge i_clk);
      ev <= ev_t[k];
      pin_go <= (k == 7 || k == 8);
      pin_len <= (k == 7) ? 10'd300 : 10'd100;
      @(posedge i_clk);
      ev <= 0;
      pin_go <= 1'b0;
      repeat ((k == 7 || k == 8) ? 420 : 3) @(posedge i_clk);
      settle();
      exp_q.push_back((k == 15) ? (r[15:0] & 16'hc2df) : ex_t[k]);
      bus(1'b0, 4'h0, 16'h0);
      $display("test %0d done", k);
    end
    exp_q.push_back(16'h0);
    bus(1'b0, 4'hc, 16'h0);
    exp_q.push_back(16'h0);
    bus(1'b0, 4'h8, 16'h0);
    @(posedge i_clk);
    close_out();
  end
endmodule // testbench
